// file: sps_regs.svh
// register addresses, field positions and reset values of the page stack
// assumes inclusion by the page stack module and its testbench only
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// special-function addresses, all reachable from every page
`define SPS_PAGE_ADDR    8'ha7
`define SPS_LVL1_ADDR    8'h85
`define SPS_LVL2_ADDR    8'h86
`define SPS_CTRL_ADDR    8'h84

// control register field position
`define SPS_CTRL_AUTO_BIT 0

// reset values
`define SPS_PAGE_RST     8'h00
`define SPS_LVL_RST      8'h00
`define SPS_CTRL_AUTO_RST 1'b1

`endif

// file: sps_pkg.sv
// types shared by the page stack modules
// assumes sps_regs.svh is compiled alongside
`default_nettype none

package sps_pkg;

    // one special-function access from the core, same clock
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sps_sfr_req_type;

    // stack movement in one cycle
    typedef enum logic [2:0] {
        SPS_OP_IDLE = 3'b001,
        SPS_OP_PUSH = 3'b010,
        SPS_OP_POP  = 3'b100
    } sps_op_type;

endpackage

`default_nettype wire

// file: sps_level.sv
// one byte of the page stack: software write, push load, pop load
// assumes the caller resolves priorities into op and sw_we
`timescale 1ns/1ns
`default_nettype none

module sps_level
    import sps_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire sps_op_type op,
    input  wire logic       sw_we,
    input  wire logic [7:0] sw_data,
    input  wire logic [7:0] push_in,
    input  wire logic [7:0] pop_in,
    output var  logic [7:0] level_q
);

    logic [7:0] level_d;

    ////////////////////////////////////////////////////////////////////////
    // stack movement outranks a software write in the same cycle
    always_comb begin
        level_d = level_q;
        case (op)
            SPS_OP_PUSH: level_d = push_in;
            SPS_OP_POP:  level_d = pop_in;
            SPS_OP_IDLE: begin
                if (sw_we) begin
                    level_d = sw_data;
                end
            end
            default:     level_d = level_q;
        endcase
    end

    // level storage
    always_ff @(posedge clock) begin
        if (rst) begin
            level_q <= RST_VAL;
        end else begin
            level_q <= level_d;
        end
    end

endmodule

`default_nettype wire

// file: sps_page_stack.sv
// page selection and page stack for the special-function register space
// assumes the core issues accesses and interrupt events on this clock
//
// How it works
// RL1: three stack bytes, each its own register
// RL2: current page register is the stack top
// RL3: push only on interrupt service
// RL4: pop only on interrupt exit
// RL5: auto paging loads the interrupting peripheral page
// RL6: exit restores level beneath, as software left
// RL7: auto enable clear stops switching and stack
// RL8: page write sets page for later accesses
// RL9: page read returns page in use
// RL10: page register access never moves the stack
// RL11: page at 0xa7, all pages, resets zero
// RL12: push shifts down, pop shifts back up
`timescale 1ns/1ns
`default_nettype none

`include "sps_regs.svh"

module sps_page_stack
    import sps_pkg::*;
#(
    parameter int DEPTH = 3
) (
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire sps_sfr_req_type sfr_req,
    input  wire logic            int_enter,
    input  wire logic [7:0]      int_page,
    input  wire logic            reti,
    output var  logic [7:0]      sfr_rdata,
    output var  logic            sfr_rd_valid,
    output var  logic [7:0]      cur_page,
    output var  logic            auto_page_enable
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration check: three addresses exist, so exactly three levels
    if (DEPTH != 3) begin : g_bad_depth
        $error("sps_page_stack: DEPTH must be 3");
    end

    // address of each stack level, top first
    localparam logic [7:0] LVL_ADDR [0:2] = '{
        `SPS_PAGE_ADDR,
        `SPS_LVL1_ADDR,
        `SPS_LVL2_ADDR
    };

    // reset value of each stack level
    localparam logic [7:0] LVL_RST [0:2] = '{
        `SPS_PAGE_RST,
        `SPS_LVL_RST,
        `SPS_LVL_RST
    };

    ////////////////////////////////////////////////////////////////////////
    // control register: automatic page enable

    logic       auto_q;
    logic       auto_d;
    logic       ctrl_wr;

    // the control register decodes on every page
    assign ctrl_wr = sfr_req.wr && (sfr_req.addr == `SPS_CTRL_ADDR);

    // next value of the enable bit
    always_comb begin
        auto_d = auto_q;
        if (ctrl_wr) begin
            auto_d = sfr_req.wdata[`SPS_CTRL_AUTO_BIT];
        end
    end

    // enable register
    always_ff @(posedge clock) begin
        if (rst) begin
            auto_q <= `SPS_CTRL_AUTO_RST;
        end else begin
            auto_q <= auto_d;
        end
    end

    assign auto_page_enable = auto_q;

    ////////////////////////////////////////////////////////////////////////
    // stack movement decision

    sps_op_type op;

    // entry outranks exit; no push or pop while auto paging is off
    always_comb begin
        op = SPS_OP_IDLE;                          // [RL10]
        if (auto_q && int_enter) begin
            op = SPS_OP_PUSH;                      // [RL3] [RL5] [RL7]
        end else if (auto_q && reti) begin
            op = SPS_OP_POP;                       // [RL4] [RL7]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stack levels, level 0 is the current page

    logic [7:0] lvl_q   [0:DEPTH-1];
    logic [7:0] push_in [0:DEPTH-1];
    logic [7:0] pop_in  [0:DEPTH-1];
    logic       lvl_we  [0:DEPTH-1];

    for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
        // push loads the page above, the top takes the peripheral page
        if (i == 0) begin : g_top
            assign push_in[i] = int_page;          // [RL5]
        end else begin : g_below
            assign push_in[i] = lvl_q[i-1];        // [RL12]
        end

        // pop loads the page below, the last level keeps its byte
        if (i == DEPTH - 1) begin : g_last
            assign pop_in[i] = lvl_q[i];
        end else begin : g_above
            assign pop_in[i] = lvl_q[i+1];         // [RL6] [RL12]
        end

        // each level is its own register on every page
        assign lvl_we[i] = sfr_req.wr
                           && (sfr_req.addr == LVL_ADDR[i]); // [RL1] [RL11]

        sps_level #(
            .RST_VAL (LVL_RST[i])
        ) u_level (
            .clock   (clock),
            .rst     (rst),
            .op      (op),
            .sw_we   (lvl_we[i]),
            .sw_data (sfr_req.wdata),
            .push_in (push_in[i]),
            .pop_in  (pop_in[i]),
            .level_q (lvl_q[i])
        );
    end

    // the page in use is simply the stack top
    assign cur_page = lvl_q[0];                    // [RL2] [RL8]

    ////////////////////////////////////////////////////////////////////////
    // read path: registered data, one cycle after the request

    logic [7:0] rdata_d;
    logic       rvalid_d;

    // read decode, reserved control bits read zero
    always_comb begin
        rdata_d  = sfr_rdata;
        rvalid_d = 1'b0;
        if (sfr_req.rd) begin
            rvalid_d = 1'b1;
            case (sfr_req.addr)
                `SPS_PAGE_ADDR: rdata_d = lvl_q[0]; // [RL9]
                `SPS_LVL1_ADDR: rdata_d = lvl_q[1]; // [RL1]
                `SPS_LVL2_ADDR: rdata_d = lvl_q[2]; // [RL1]
                `SPS_CTRL_ADDR: begin
                    rdata_d = 8'h00;
                    rdata_d[`SPS_CTRL_AUTO_BIT] = auto_q;
                end
                default: begin
                    rdata_d  = sfr_rdata;
                    rvalid_d = 1'b0;
                end
            endcase
        end
    end

    // read data and valid registers
    always_ff @(posedge clock) begin
        if (rst) begin
            sfr_rdata    <= 8'h00;
            sfr_rd_valid <= 1'b0;
        end else begin
            sfr_rdata    <= rdata_d;
            sfr_rd_valid <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the stack behaviour

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // helper terms read by the checks only
    logic any_lvl_wr;
    logic deep_wr;
    assign any_lvl_wr = lvl_we[0] || lvl_we[1] || lvl_we[2];
    assign deep_wr    = lvl_we[1] || lvl_we[2];

    // interrupt entry with paging on
    sequence s_enter;
        auto_q && int_enter;
    endsequence

    // clean interrupt exit with paging on
    sequence s_exit;
        auto_q && reti && !int_enter;
    endsequence

    // entry puts the peripheral page on top
    property p_enter_page; // [RL5]
        s_enter |=> cur_page == $past(int_page);
    endproperty
    a_enter_page: assert property (p_enter_page) // [RL5]
        else $error("entry did not switch to the peripheral page");

    // entry shifts every level down one place
    property p_push_shift; // [RL12]
        s_enter |=> (lvl_q[1] == $past(lvl_q[0]))
                    && (lvl_q[2] == $past(lvl_q[1]));
    endproperty
    a_push_shift: assert property (p_push_shift) // [RL12]
        else $error("push did not shift the levels");

    // exit brings the level beneath back to the top
    property p_pop_restore; // [RL6]
        s_exit |=> (lvl_q[0] == $past(lvl_q[1]))
                   && (lvl_q[1] == $past(lvl_q[2]));
    endproperty
    a_pop_restore: assert property (p_pop_restore) // [RL6]
        else $error("pop did not restore the level beneath");

    // an entry followed by an exit lands on the page before the entry
    property p_round_trip; // [RL4]
        s_enter ##1 s_exit |=> cur_page == $past(cur_page, 2);
    endproperty
    a_round_trip: assert property (p_round_trip) // [RL4]
        else $error("entry then exit did not return to the old page");

    // paging off: only software writes move the levels
    property p_disabled_still; // [RL7]
        (!auto_q && !any_lvl_wr) |=> $stable(lvl_q[0])
                                     && $stable(lvl_q[1])
                                     && $stable(lvl_q[2]);
    endproperty
    a_disabled_still: assert property (p_disabled_still) // [RL7]
        else $error("stack moved while auto paging was off");

    // without entry or exit the lower levels hold, page accesses included
    property p_no_stray_move; // [RL10]
        (!int_enter && !reti && !deep_wr) |=> $stable(lvl_q[1])
                                              && $stable(lvl_q[2]);
    endproperty
    a_no_stray_move: assert property (p_no_stray_move) // [RL10]
        else $error("stack moved without an interrupt event");

    // a page write with no interrupt event takes the written value
    property p_page_write; // [RL8]
        (lvl_we[0] && !(auto_q && (int_enter || reti)))
            |=> cur_page == $past(sfr_req.wdata);
    endproperty
    a_page_write: assert property (p_page_write) // [RL8]
        else $error("page write did not set the current page");

    // a page read answers next cycle with the page in use
    property p_page_read; // [RL9]
        (sfr_req.rd && sfr_req.addr == `SPS_PAGE_ADDR)
            |=> sfr_rd_valid && (sfr_rdata == $past(cur_page));
    endproperty
    a_page_read: assert property (p_page_read) // [RL9]
        else $error("page read returned the wrong value");

    // leaving reset the page is zero and paging is on
    property p_reset_page; // [RL11]
        $fell(rst) |-> (cur_page == 8'h00) && auto_q;
    endproperty
    a_reset_page: assert property (p_reset_page) // [RL11]
        else $error("page stack left reset with wrong values");

    // entry and exit together: the push wins, nothing is popped
    property p_enter_wins; // [RL4]
        (auto_q && int_enter && reti)
            |=> (cur_page == $past(int_page))
                && (lvl_q[1] == $past(lvl_q[0]));
    endproperty
    a_enter_wins: assert property (p_enter_wins) // [RL4]
        else $error("exit was not beaten by entry in one cycle");

    // a next-level write with no stack movement takes the written value
    property p_deep_write; // [RL1]
        (lvl_we[1] && !(auto_q && (int_enter || reti)))
            |=> lvl_q[1] == $past(sfr_req.wdata);
    endproperty
    a_deep_write: assert property (p_deep_write) // [RL1]
        else $error("next level write did not land");

    // a control write sets or clears automatic paging
    property p_ctrl_write; // [RL7]
        ctrl_wr |=> auto_q == $past(sfr_req.wdata[`SPS_CTRL_AUTO_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // [RL7]
        else $error("control write did not set the enable bit");

    // a read of an address outside the block gives no valid strobe
    property p_miss_no_valid; // [RL11]
        (sfr_req.rd && !(sfr_req.addr inside {`SPS_PAGE_ADDR,
                                              `SPS_LVL1_ADDR,
                                              `SPS_LVL2_ADDR,
                                              `SPS_CTRL_ADDR}))
            |=> !sfr_rd_valid;
    endproperty
    a_miss_no_valid: assert property (p_miss_no_valid) // [RL11]
        else $error("read of a foreign address raised valid");

endmodule

`default_nettype wire

// file: sps_core_model.sv
// core-side model: issues sfr accesses and interrupt entry and exit
// assumes one clock shared with the page stack, drives on falling edges
`timescale 1ns/1ns
`default_nettype none

module sps_core_model
    import sps_pkg::*;
(
    input  wire logic            clock,
    input  wire logic [7:0]      sfr_rdata,
    input  wire logic            sfr_rd_valid,
    output var  sps_sfr_req_type sfr_req,
    output var  logic            int_enter,
    output var  logic [7:0]      int_page,
    output var  logic            reti
);
    // idle bus at time zero
    initial begin
        sfr_req   = '0;
        int_enter = 1'b0;
        int_page  = 8'h00;
        reti      = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle write, data line inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_req.wr    = 1'b1;
        sfr_req.addr  = a;
        sfr_req.wdata = d;
        @(negedge clock);
        sfr_req.wr    = 1'b0;
        sfr_req.wdata = ~d;
    endtask

    // one-cycle read, answer sampled one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] q,
                      output logic v);
        @(negedge clock);
        sfr_req.rd   = 1'b1;
        sfr_req.addr = a;
        @(negedge clock);
        sfr_req.rd   = 1'b0;
        v            = sfr_rd_valid;
        q            = sfr_rdata;
    endtask

    // interrupt service with the peripheral page
    task automatic irq(input logic [7:0] p);
        @(negedge clock);
        int_enter = 1'b1;
        int_page  = p;
        @(negedge clock);
        int_enter = 1'b0;
        int_page  = ~p;
    endtask

    // entry, exit and a write all in one cycle, for priority checks
    task automatic clash(input logic [7:0] p, input logic [7:0] a,
                         input logic [7:0] d);
        @(negedge clock);
        int_enter     = 1'b1;
        int_page      = p;
        reti          = 1'b1;
        sfr_req.wr    = 1'b1;
        sfr_req.addr  = a;
        sfr_req.wdata = d;
        @(negedge clock);
        int_enter     = 1'b0;
        int_page      = ~p;
        reti          = 1'b0;
        sfr_req.wr    = 1'b0;
        sfr_req.wdata = ~d;
    endtask

    // return from interrupt
    task automatic ret();
        @(negedge clock);
        reti = 1'b1;
        @(negedge clock);
        reti = 1'b0;
    endtask
endmodule

`default_nettype wire

// file: test_sfr_page_stack.sv
// self-checking bench for the page stack
// assumes sps_pkg, sps_regs.svh and the core model are compiled first
`timescale 1ns/1ns
`default_nettype none

`include "sps_regs.svh"

module test_sfr_page_stack
    import sps_pkg::*;
;

    logic            clock;
    logic            rst;
    sps_sfr_req_type sfr_req;
    logic            int_enter;
    logic [7:0]      int_page;
    logic            reti;
    logic [7:0]      sfr_rdata;
    logic            sfr_rd_valid;
    logic [7:0]      cur_page;
    logic            auto_page_enable;
    int              n_errors;
    int              cmp_count;

    sps_page_stack #(.DEPTH(3)) dut (
        .clock(clock), .rst(rst), .sfr_req(sfr_req),
        .int_enter(int_enter), .int_page(int_page), .reti(reti),
        .sfr_rdata(sfr_rdata), .sfr_rd_valid(sfr_rd_valid),
        .cur_page(cur_page), .auto_page_enable(auto_page_enable));

    sps_core_model core (
        .clock(clock), .sfr_rdata(sfr_rdata),
        .sfr_rd_valid(sfr_rd_valid), .sfr_req(sfr_req),
        .int_enter(int_enter), .int_page(int_page), .reti(reti));

    ////////////////////////////////////////////////////////////////////////
    // clock, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // verdict and end of run
    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // compare one byte
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // read a register, expect a valid answer with the given byte
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       v;
        core.rd(a, q, v);
        check({7'h00, v}, 8'h01);
        check(q, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset values of every register
    task automatic t_reset();
        rchk(`SPS_PAGE_ADDR, 8'h00);
        rchk(`SPS_LVL1_ADDR, 8'h00);
        rchk(`SPS_LVL2_ADDR, 8'h00);
        rchk(`SPS_CTRL_ADDR, 8'h01);
        check(cur_page, 8'h00);
    endtask

    // page write and read leave the stack alone
    task automatic t_page();
        core.wr(`SPS_PAGE_ADDR, 8'h05);
        check(cur_page, 8'h05);
        rchk(`SPS_PAGE_ADDR, 8'h05);
        rchk(`SPS_LVL1_ADDR, 8'h00);
        rchk(`SPS_LVL2_ADDR, 8'h00);
    endtask

    // three pushes overflow the last level, then one pop
    task automatic t_push_pop();
        core.irq(8'h11);
        core.irq(8'h22);
        core.irq(8'h33);
        check(cur_page, 8'h33);
        rchk(`SPS_LVL1_ADDR, 8'h22);
        rchk(`SPS_LVL2_ADDR, 8'h11);
        core.ret();
        check(cur_page, 8'h22);
        rchk(`SPS_LVL1_ADDR, 8'h11);
        rchk(`SPS_LVL2_ADDR, 8'h11);
    endtask

    // handler alters the next level, exit returns to it
    task automatic t_alter();
        core.wr(`SPS_LVL1_ADDR, 8'h44);
        core.ret();
        check(cur_page, 8'h44);
        rchk(`SPS_PAGE_ADDR, 8'h44);
    endtask

    // auto paging off: entry and exit change nothing
    task automatic t_auto_off();
        core.wr(`SPS_CTRL_ADDR, 8'h00);
        check({7'h00, auto_page_enable}, 8'h00);
        core.irq(8'h66);
        check(cur_page, 8'h44);
        core.ret();
        check(cur_page, 8'h44);
        rchk(`SPS_LVL1_ADDR, 8'h11);
        core.wr(`SPS_CTRL_ADDR, 8'hff);
        rchk(`SPS_CTRL_ADDR, 8'h01);
    endtask

    // unmapped address: write ignored, read without valid
    task automatic t_unmapped();
        logic [7:0] q;
        logic       v;
        core.wr(8'h90, 8'h77);
        core.rd(8'h90, q, v);
        check({7'h00, v}, 8'h00);
        check(q, 8'h01);
        check(cur_page, 8'h44);
    endtask

    // entry, exit and a next-level write together: only the push acts
    task automatic t_collide();
        core.clash(8'h55, `SPS_LVL1_ADDR, 8'h99);
        check(cur_page, 8'h55);
        rchk(`SPS_LVL1_ADDR, 8'h44);
        rchk(`SPS_LVL2_ADDR, 8'h11);
    endtask

    // reset in mid-run returns every register to its reset value
    task automatic t_rerst();
        core.wr(`SPS_CTRL_ADDR, 8'h00);
        @(negedge clock);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        check(cur_page, 8'h00);
        check({7'h00, auto_page_enable}, 8'h01);
        rchk(`SPS_LVL1_ADDR, 8'h00);
        rchk(`SPS_LVL2_ADDR, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_errors  = 0;
        cmp_count = 0;
        rst       = 1'b1;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_page();
        t_push_pop();
        t_alter();
        t_auto_off();
        t_unmapped();
        t_collide();
        t_rerst();
        complete_run();
    end

    // watchdog, well beyond the expected run of under a hundred cycles
    initial begin
        repeat (2000) @(posedge clock);
        n_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
